// file: fcc_ctrl.sv
/*
  flash command control register and unlock sequencer: holds the control
  register, checks the unlock key sequence, decodes the operation and times
  a self-timed erase or program, then clears the go bit.
  assumes cpu register writes are synchronous one-cycle strobes on clock and
  that resetn is the power-on reset only; other resets do not reach here.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: go bit set-only, hardware clears at end
// R2: enable bit zero inhibits any operation
// R3: fault set on improper or aborted sequence
// R4: fault reads zero after normal completion
// R5: erase selector picks erase or program
// R6: erase codes decoded, 0011 and 0001 no-op
// R7: program codes decoded, listed codes no-op
// R8: unlisted codes never start an operation
// R9: control bits reset only by power-on reset
// R10: software writes 55 then AA first
// R11: erase code 0010 is eight-row page erase
// R12: program code 0001 is single row program
// R13: unimplemented bits ignore writes, read zero
module fcc_ctrl
  import fcc_pkg::*;
#(
  parameter int OP_CYCLES = FCC_OP_CYCLES
)(
  // clock and power-on reset
  input  wire logic     clock,
  input  wire logic     resetn,
  // cpu register access
  input  wire fcc_wr_t  ctrl_wr,
  input  wire logic     key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic     abort_req,
  // register read back
  output logic [15:0]   flash_cmd_ctrl,
  // flash array command
  output fcc_cmd_t      array_cmd,
  output logic          cpu_stall
);
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} fcc_key_t;

  logic       go_reg, go_next;
  logic       en_reg, en_next;
  logic       fault_reg, fault_next;
  logic       erase_reg, erase_next;
  logic [3:0] op_select_reg, op_select_next;
  fcc_key_t   key_reg, key_next;
  fcc_cmd_t   cmd_reg, cmd_next;
  logic       stall_reg, stall_next;
  fcc_op_t    decoded;
  logic       go_attempt;
  logic       launch;
  logic       tmr_done;

  // operation decode from selector and field
  always_comb begin
    decoded = FCC_OP_NONE;
    if (erase_reg) begin // R5
      case (op_select_reg) // R6
        FCC_ER_BULK:    decoded = FCC_OP_BULK;
        FCC_ER_GENSEG:  decoded = FCC_OP_GENSEG;
        FCC_ER_SECSEG:  decoded = FCC_OP_SECSEG;
        FCC_ER_PAGE:    decoded = FCC_OP_PAGE; // R11
        FCC_ER_CFGBYTE: decoded = FCC_OP_CFG_ERASE;
        default:        decoded = FCC_OP_NONE; // R8
      endcase
    end else begin
      case (op_select_reg) // R7
        FCC_PG_WORD:    decoded = FCC_OP_WORD;
        FCC_PG_ROW:     decoded = FCC_OP_ROW; // R12
        FCC_PG_CFGBYTE: decoded = FCC_OP_CFG_ERASE; // config byte, same FCC_OP_CFG_ERASE as the erase code
        default:        decoded = FCC_OP_NONE; // R8
      endcase
    end
  end

  // a write that tries to set go while idle
  assign go_attempt = ctrl_wr.wr && ctrl_wr.data[FCC_GO_BIT] && !go_reg;
  // start only when unlocked, enabled and the code is implemented
  assign launch = go_attempt && (key_reg == KEY_OPEN) && en_reg // R10 R2
                  && (decoded != FCC_OP_NONE); // R8

  // unlock key sequencer
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      KEY_IDLE: if (key_wr && key_data == FCC_KEY_FIRST) key_next = KEY_HALF; // R10
      KEY_HALF: begin
        if (key_wr) key_next = (key_data == FCC_KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
        else if (ctrl_wr.wr) key_next = KEY_IDLE;
      end
      KEY_OPEN: if (key_wr || ctrl_wr.wr) key_next = KEY_IDLE; // consumed by next write
      default:  key_next = KEY_IDLE;
    endcase
  end

  // control register next values
  always_comb begin
    go_next        = go_reg;
    en_next        = en_reg;
    fault_next     = fault_reg;
    erase_next     = erase_reg;
    op_select_next = op_select_reg;
    cmd_next       = '{start: 1'b0, op: FCC_OP_NONE};
    stall_next     = stall_reg;
    if (ctrl_wr.wr && !go_reg) begin // fields frozen while busy
      en_next        = ctrl_wr.data[FCC_EN_BIT];
      fault_next     = ctrl_wr.data[FCC_FAULT_BIT];
      erase_next     = ctrl_wr.data[FCC_ERASE_BIT];
      op_select_next = ctrl_wr.data[3:0] & FCC_WRITE_MASK[3:0]; // R13
    end
    if (go_attempt) begin
      if (launch) begin
        go_next    = 1'b1; // R1
        fault_next = 1'b0;
        stall_next = 1'b1;
        cmd_next   = '{start: 1'b1, op: decoded};
      end else begin
        fault_next = 1'b1; // R3
      end
    end
    if (go_reg && abort_req) begin
      go_next    = 1'b0;
      fault_next = 1'b1; // R3
      stall_next = 1'b0;
    end else if (go_reg && tmr_done) begin
      go_next    = 1'b0; // R1
      fault_next = 1'b0; // R4
      stall_next = 1'b0;
    end
  end

  // registers, cleared only by power-on reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin // R9
      go_reg        <= FCC_CTRL_RESET[FCC_GO_BIT];
      en_reg        <= FCC_CTRL_RESET[FCC_EN_BIT];
      fault_reg     <= FCC_CTRL_RESET[FCC_FAULT_BIT];
      erase_reg     <= FCC_CTRL_RESET[FCC_ERASE_BIT];
      op_select_reg <= FCC_CTRL_RESET[3:0];
      key_reg       <= KEY_IDLE;
      cmd_reg       <= '{start: 1'b0, op: FCC_OP_NONE};
      stall_reg     <= 1'b0;
    end else begin
      go_reg        <= go_next;
      en_reg        <= en_next;
      fault_reg     <= fault_next;
      erase_reg     <= erase_next;
      op_select_reg <= op_select_next;
      key_reg       <= key_next;
      cmd_reg       <= cmd_next;
      stall_reg     <= stall_next;
    end
  end

  // operation timer
  fcc_timer u_timer (
    .clock  (clock),
    .resetn (resetn),
    .load   (launch),
    .abort  (go_reg && abort_req),
    .length (FCC_CNT_W'(OP_CYCLES)),
    .busy   (),
    .done   (tmr_done)
  );

  // read back, unimplemented bits zero
  assign flash_cmd_ctrl = {go_reg, en_reg, fault_reg, 6'h00, erase_reg, 2'h0,
                           op_select_reg}; // R13
  assign array_cmd      = cmd_reg;
  assign cpu_stall      = stall_reg;
endmodule
`default_nettype wire

// file: fcc_pkg.sv
/*
  package for the flash command control block: register layout, reset values,
  operation encodings, key values and the timing constants.
  assumes nothing of its surroundings.
*/
`default_nettype none
package fcc_pkg;
  // control register field positions
  localparam int          FCC_GO_BIT      = 15;
  localparam int          FCC_EN_BIT      = 14;
  localparam int          FCC_FAULT_BIT   = 13;
  localparam int          FCC_ERASE_BIT   = 6;
  localparam logic [15:0] FCC_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] FCC_WRITE_MASK  = 16'h604F; // en, fault, erase, op_select
  // unlock key values
  localparam logic [7:0]  FCC_KEY_FIRST   = 8'h55;
  localparam logic [7:0]  FCC_KEY_SECOND  = 8'hAA;
  // erase codes
  localparam logic [3:0]  FCC_ER_BULK     = 4'hF;
  localparam logic [3:0]  FCC_ER_GENSEG   = 4'hE;
  localparam logic [3:0]  FCC_ER_SECSEG   = 4'hD;
  localparam logic [3:0]  FCC_ER_PAGE     = 4'h2;
  localparam logic [3:0]  FCC_ER_CFGBYTE  = 4'h0;
  // program codes
  localparam logic [3:0]  FCC_PG_WORD     = 4'h3;
  localparam logic [3:0]  FCC_PG_ROW      = 4'h1;
  localparam logic [3:0]  FCC_PG_CFGBYTE  = 4'h0;
  // clock rate and default operation time
  localparam int          FCC_CLK_HZ      = 40000000;
  localparam int          FCC_OP_TIME_US  = 1000;
  localparam int          FCC_OP_CYCLES   = FCC_CLK_HZ / 1000000 * FCC_OP_TIME_US;
  localparam int          FCC_CNT_W       = 24;
  // operation kinds handed to the array
  typedef enum logic [2:0] {
    FCC_OP_NONE, FCC_OP_BULK, FCC_OP_GENSEG, FCC_OP_SECSEG, FCC_OP_PAGE,
    FCC_OP_CFG_ERASE, FCC_OP_WORD, FCC_OP_ROW
  } fcc_op_t;
  // command to the flash array
  typedef struct packed {
    logic    start;
    fcc_op_t op;
  } fcc_cmd_t;
  // control register write from the cpu
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } fcc_wr_t;
endpackage
`default_nettype wire

// file: fcc_timer.sv
/*
  down counter that times one flash operation and reports completion.
  assumes a single clock domain and a load value above zero.
*/
`timescale 1ns/1ps
`default_nettype none
module fcc_timer
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // control
  input  wire logic                 load,
  input  wire logic                 abort,
  input  wire logic [FCC_CNT_W-1:0] length,
  // status
  output logic                      busy,
  output logic                      done
);
  logic [FCC_CNT_W-1:0] cnt_reg;
  logic [FCC_CNT_W-1:0] cnt_next;
  logic                 busy_reg;
  logic                 busy_next;
  logic                 done_reg;
  logic                 done_next;

  // next count and completion pulse
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
    end else if (load) begin
      cnt_next  = length;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg <= FCC_CNT_W'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - FCC_CNT_W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule
`default_nettype wire

// file: fcc_ctrl_checker.sv
/*
  checker for the flash command control block: start, decode and register timing.
  assumes one clock and the power-on reset; bound to the top module by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl_checker
  import fcc_pkg::*;
#(parameter int OP_CYCLES = 10)(
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // cpu side
  input wire fcc_wr_t     ctrl_wr,
  input wire logic        key_wr,
  input wire logic [7:0]  key_data,
  input wire logic        abort_req,
  // outputs watched
  input wire logic [15:0] flash_cmd_ctrl,
  input wire fcc_cmd_t    array_cmd,
  input wire logic        cpu_stall
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [15:0] cnt_reg;
  // counts cycles of one go period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cnt_reg <= 16'h0000;
    else cnt_reg <= flash_cmd_ctrl[15] ? cnt_reg + 16'h0001 : 16'h0000;
  end
  property p_go_start; $rose(flash_cmd_ctrl[15]) |-> array_cmd.start; endproperty
  a_go_start: assert property (p_go_start) else $error("go rose without start");
  property p_start_en; array_cmd.start |-> flash_cmd_ctrl[15] && flash_cmd_ctrl[14]; endproperty
  a_start_en: assert property (p_start_en) else $error("start without go and enable");
  property p_once; array_cmd.start |=> !array_cmd.start; endproperty
  a_once: assert property (p_once) else $error("start longer than one cycle");
  property p_stall; cpu_stall == flash_cmd_ctrl[15]; endproperty
  a_stall: assert property (p_stall) else $error("stall differs from go");
  property p_len; cnt_reg <= OP_CYCLES + 2; endproperty
  a_len: assert property (p_len) else $error("go held too long");
  property p_unimpl; flash_cmd_ctrl[12:7] == 6'h00 && flash_cmd_ctrl[5:4] == 2'h0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bits not zero");
  property p_refuse;
    ctrl_wr.wr && ctrl_wr.data[15] && !flash_cmd_ctrl[15] && !flash_cmd_ctrl[14]
      |=> flash_cmd_ctrl[13] && !flash_cmd_ctrl[15];
  endproperty
  a_refuse: assert property (p_refuse) else $error("disabled go not refused");
  property p_kind; array_cmd.start && !flash_cmd_ctrl[6]
    |-> array_cmd.op inside {FCC_OP_WORD, FCC_OP_ROW, FCC_OP_CFG_ERASE}; endproperty
  a_kind: assert property (p_kind) else $error("program started an erase");
  property p_page; array_cmd.start && flash_cmd_ctrl[6] && flash_cmd_ctrl[3:0] == FCC_ER_PAGE
    |-> array_cmd.op == FCC_OP_PAGE; endproperty
  a_page: assert property (p_page) else $error("page erase decode wrong");
  property p_none; array_cmd.start |-> array_cmd.op != FCC_OP_NONE; endproperty
  a_none: assert property (p_none) else $error("start with no operation");
  property p_done_fault;
    $fell(flash_cmd_ctrl[15]) && !$past(abort_req) |-> !flash_cmd_ctrl[13];
  endproperty
  a_done_fault: assert property (p_done_fault) else $error("fault after normal end");
  property p_row; array_cmd.start && !flash_cmd_ctrl[6] && flash_cmd_ctrl[3:0] == FCC_PG_ROW
    |-> array_cmd.op == FCC_OP_ROW; endproperty
  a_row: assert property (p_row) else $error("row program decode wrong");
endmodule
`default_nettype wire

// file: flash_cmd_control_bench.sv
/*
  bench for the flash command control block: key, control writes, decode table.
  assumes the design at OP_CYCLES 10 and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_control_bench
  import fcc_pkg::*;
;
  localparam int OP_CYCLES = 10;
  logic clock = 1'b0, resetn = 1'b0, key_wr = 1'b0, abort_req = 1'b0, cpu_stall;
  logic [7:0] key_data = 8'h00;
  logic [15:0] flash_cmd_ctrl;
  fcc_wr_t ctrl_wr = '0;
  fcc_cmd_t array_cmd;
  int error_cnt = 0, compares = 0, starts = 0;
  fcc_op_t seen_op;
  fcc_ctrl #(.OP_CYCLES(OP_CYCLES)) dut_u (.clock(clock), .resetn(resetn), .ctrl_wr(ctrl_wr),
    .key_wr(key_wr), .key_data(key_data), .abort_req(abort_req),
    .flash_cmd_ctrl(flash_cmd_ctrl), .array_cmd(array_cmd), .cpu_stall(cpu_stall));
  // clock and start monitor
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (array_cmd.start === 1'b1) begin
    starts++;
    seen_op = array_cmd.op;
  end
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin error_cnt++; $display("[ERR] %s exp %h seen %h", nm, exp, seen); end
  endtask
  task automatic wr_ctrl(logic [15:0] d);
    @(posedge clock); ctrl_wr <= '{1'b1, d};
    @(posedge clock); ctrl_wr.wr <= 1'b0; #1;
  endtask
  task automatic wr_key(logic [7:0] k);
    @(posedge clock); key_wr <= 1'b1; key_data <= k;
    @(posedge clock); key_wr <= 1'b0; #1;
  endtask
  // set fields, unlock, go; then wait for the go bit to clear
  task automatic run(logic [15:0] f, fcc_op_t op, bit ab);
    int s;
    wr_ctrl(f); wr_key(FCC_KEY_FIRST); wr_key(FCC_KEY_SECOND);
    s = starts; wr_ctrl(f | 16'h8000);
    check("stall", 16'(cpu_stall), 16'(op != FCC_OP_NONE));
    if (ab) begin @(posedge clock); abort_req <= 1'b1; @(posedge clock); abort_req <= 1'b0; end
    else if (op != FCC_OP_NONE) wr_ctrl(16'h0000); // ignored while busy
    for (int i = 0; i < OP_CYCLES + 8 && flash_cmd_ctrl[15] !== 1'b0; i++) @(posedge clock);
    #1 check("starts", 16'(starts - s), 16'(op != FCC_OP_NONE));
    if (op != FCC_OP_NONE) check("op", 16'(seen_op), 16'(op));
    check("ctrl", flash_cmd_ctrl,
          (f & 16'h604F) | ((op == FCC_OP_NONE || ab) ? 16'h2000 : 16'h0000));
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin #(25 * 6000); error_cnt++; conclude; end
  initial begin
    repeat (16) @(posedge clock); resetn <= 1'b1; #1;
    check("reset", flash_cmd_ctrl, FCC_CTRL_RESET);
    wr_ctrl(16'hFFFF); check("wmask", flash_cmd_ctrl, 16'h604F);
    run(16'h4042, FCC_OP_PAGE, 0); run(16'h404F, FCC_OP_BULK, 0);
    run(16'h404E, FCC_OP_GENSEG, 0); run(16'h404D, FCC_OP_SECSEG, 0);
    run(16'h4040, FCC_OP_CFG_ERASE, 0); run(16'h4003, FCC_OP_WORD, 0);
    run(16'h4001, FCC_OP_ROW, 0); run(16'h4000, FCC_OP_CFG_ERASE, 0);
    run(16'h4043, FCC_OP_NONE, 0); run(16'h4041, FCC_OP_NONE, 0);
    run(16'h4045, FCC_OP_NONE, 0);
    run(16'h400F, FCC_OP_NONE, 0); run(16'h400D, FCC_OP_NONE, 0);
    run(16'h400C, FCC_OP_NONE, 0);
    run(16'h4002, FCC_OP_NONE, 0); run(16'h4007, FCC_OP_NONE, 0);
    run(16'h0042, FCC_OP_NONE, 0);
    run(16'h4001, FCC_OP_ROW, 1);
    wr_ctrl(16'h4042); wr_key(FCC_KEY_SECOND); wr_key(FCC_KEY_FIRST); wr_ctrl(16'hC042);
    check("badkey", flash_cmd_ctrl, 16'h6042);
    wr_ctrl(16'h4042); wr_key(FCC_KEY_FIRST); wr_key(FCC_KEY_SECOND); wr_ctrl(16'hC042);
    @(posedge clock); resetn <= 1'b0; @(posedge clock); resetn <= 1'b1; #1;
    check("midreset", flash_cmd_ctrl, FCC_CTRL_RESET);
    conclude;
  end
endmodule
bind fcc_ctrl fcc_ctrl_checker #(.OP_CYCLES(OP_CYCLES)) chk_u (.clock(clock), .resetn(resetn),
  .ctrl_wr(ctrl_wr), .key_wr(key_wr), .key_data(key_data), .abort_req(abort_req),
  .flash_cmd_ctrl(flash_cmd_ctrl), .array_cmd(array_cmd), .cpu_stall(cpu_stall));
`default_nettype wire
